// ### design/memspace_pkg.sv
/*
  Constants, commands and carriers for the memory space decoder.
  Assumes a single 40 MHz core clock and an asynchronous active-low reset.
*/
`default_nettype none
package memspace_pkg;

  // internal memory map
  localparam int          INT_MEM_BYTES = 384;
  localparam int          INT_RAM_BYTES = 256;
  localparam int          SREG_BYTES    = 128;
  localparam logic [7:0]  INT_BASE      = 8'h00;
  localparam logic [7:0]  UPPER_BASE    = 8'h80;
  localparam logic [7:0]  BIT_RAM_BASE  = 8'h20;
  localparam logic [7:0]  SP_ADDR       = 8'h81;
  localparam logic [7:0]  PSW_ADDR      = 8'hD0;
  localparam logic [7:0]  SP_RESET      = 8'h07;
  localparam logic [7:0]  PSW_RESET     = 8'h00;
  localparam int          PSW_BANK_LSB  = 3;
  localparam int          BANK_REGS     = 8;

  // program space vectors
  localparam logic [15:0] RESET_VECTOR  = 16'h0000;
  localparam logic [15:0] VECTOR_BASE   = 16'h0003;
  localparam logic [15:0] VECTOR_STEP   = 16'h0008;
  localparam logic [15:0] DP_RESET      = 16'h0000;

  // external strobe width
  localparam int CLK_PERIOD_NS = 25;
  localparam int EXT_WAIT_NS   = 100;
  localparam int EXT_WAIT_CYC  = (EXT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // external segment decode, base and compare mask
  localparam logic [15:0] MAIN_BASE = 16'h0000;
  localparam logic [15:0] MAIN_MASK = 16'h8000;
  localparam logic [15:0] SEC_BASE  = 16'h8000;
  localparam logic [15:0] SEC_MASK  = 16'h8000;
  localparam logic [15:0] SRAM_BASE = 16'h2000;
  localparam logic [15:0] SRAM_MASK = 16'hF000;
  localparam logic [15:0] CTRL_BASE = 16'h0200;
  localparam logic [15:0] CTRL_MASK = 16'hFF00;

  // chip select positions
  localparam int CS_MAIN  = 0;
  localparam int CS_SEC   = 1;
  localparam int CS_SRAM  = 2;
  localparam int CS_CTRL  = 3;
  localparam int CS_COUNT = 4;

  typedef enum logic [4:0] {
    OP_NOP      = 5'h00,
    OP_DIR_RD   = 5'h01,
    OP_DIR_WR   = 5'h02,
    OP_IND_RD   = 5'h03,
    OP_IND_WR   = 5'h04,
    OP_BIT_SET  = 5'h05,
    OP_BIT_CLR  = 5'h06,
    OP_BIT_TST  = 5'h07,
    OP_REG_RD   = 5'h08,
    OP_REG_WR   = 5'h09,
    OP_PUSH     = 5'h0A,
    OP_POP      = 5'h0B,
    OP_FETCH    = 5'h0C,
    OP_JUMP     = 5'h0D,
    OP_IRQ      = 5'h0E,
    OP_XRD      = 5'h0F,
    OP_XWR      = 5'h10,
    OP_DATA_POINTER_REG_LD  = 5'h11,
    OP_DATA_POINTER_REG_SEL = 5'h12,
    OP_PLACE_WR = 5'h13
  } op_e;

  typedef struct packed {
    logic        valid;
    op_e         op;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [15:0] wide;
  } core_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
    logic       bit_val;
  } core_rsp_s;

  typedef struct packed {
    logic main_prog;
    logic main_data;
    logic sec_prog;
    logic sec_data;
  } placement_s;

  typedef struct packed {
    logic [15:0]         addr;
    logic [7:0]          page;
    logic [7:0]          wdata;
    logic                program_fetch_strobe_n;
    logic                rd_n;
    logic                wr_n;
    logic [CS_COUNT-1:0] cs;
  } ext_bus_s;

endpackage
`default_nettype wire

// ### design/special_register_store.sv
/*
  Separate byte store behind the direct-only special register space.
  Assumes the parent routes only direct accesses at 0x80..0xFF here.
*/
`timescale 1ns/10ps
`default_nettype none
module special_register_store
  import memspace_pkg::*;
#(
  parameter int DEPTH = SREG_BYTES
)
(
  // clock
  input  wire logic       clk,
  // write port
  input  wire logic       wr_en,
  input  wire logic [6:0] waddr,
  input  wire logic [7:0] wdata,
  // read port
  input  wire logic [6:0] raddr,
  output logic      [7:0] rdata
);

  logic [7:0] store_q [DEPTH];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      store_q[waddr] <= wdata;
    end
  end

  assign rdata = store_q[raddr];

endmodule
`default_nettype wire

// ### design/mcu_memory_space_decoder.sv
/*
  Memory space decoder of the core: internal RAM, special register space,
  working register banks, bit space, stack, program counter, data pointers
  and external program/data strobes with segment chip selects.
  Assumes one request at a time, issued only while busy is low, and an
  external memory that returns read data by the end of the strobe.
*/
// What this block does
// - internal memory is a fixed 384-byte on-chip region starting at zero
// - external program and data each own a separately decoded 64K space
// - every external program access, fetches included, uses only the fetch strobe
// - external data reads use read strobe, writes use write strobe only
// - internal accesses keep the external read and write strobes high
// - addresses 0x00 to 0x7F answer both direct and indirect addressing
// - 0x00 to 0x1F hold four banks of eight registers, one active
// - bytes 0x20 to 0x2F also serve as 128 single bits
// - RAM at 0x80 to 0xFF is reached only by indirect addressing
// - push and pop are indirect so the stack spans all 256 bytes
// - special registers overlay 0x80 to 0xFF, reached only directly
// - only special registers at addresses ending 0 or 8 are bit-addressable
// - fetches use a 16-bit program counter over the whole 64K space
// - after any reset fetching starts at program address zero
// - interrupts vector to fixed addresses eight bytes apart from 0x0003
// - external data is addressed through a 16-bit data pointer
// - two data pointers are provided, one selected at a time for both reads and writes
// - module SRAM and control registers live only in data space
// - flash placement loads from nonvolatile setting on the first clock after reset release, runtime overridable
// - firmware may move flash to data space for update, then back
// - segments are chosen by address decode combined with placement; the page value is only driven out on the bus
`timescale 1ns/10ps
`default_nettype none
module mcu_memory_space_decoder
  import memspace_pkg::*;
#(
  parameter int WAIT_CYCLES = EXT_WAIT_CYC
)
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // core request and answer
  input  wire core_req_s  req,
  output core_rsp_s       rsp,
  output logic            busy,
  // nonvolatile placement and page value
  input  wire placement_s nv_placement,
  input  wire logic [7:0] page,
  // external memory module
  output ext_bus_s        ext_bus,
  input  wire logic [7:0] ext_rdata,
  // state shown to the core
  output logic [15:0]     pc,
  output placement_s      placement,
  output logic [1:0]      active_bank
);

  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_IDLE = 3'b010,
    ST_EXT  = 3'b100
  } state_e;

  localparam int CNT_W = $clog2(WAIT_CYCLES + 1);

  state_e            state_q;
  logic [CNT_W-1:0]  wait_q;
  logic [7:0]        ram_q [INT_RAM_BYTES];
  logic [7:0]        sp_q;
  logic [7:0]        psw_q;
  logic [1:0][15:0]  data_pointer_reg_q;
  logic              dsel_q;
  logic              ext_read_q;

  // bit address to holding byte address
  function automatic logic [7:0] bit_byte(input logic [7:0] bit_addr);
    if (bit_addr[7])
      return {bit_addr[7:3], 3'b000};
    else
      return BIT_RAM_BASE + {4'h0, bit_addr[6:3]};
  endfunction

  // segment chip selects for one external access
  function automatic logic [CS_COUNT-1:0] seg_select(input logic prog,
                                                     input logic [15:0] a,
                                                     input placement_s pl);
    logic [CS_COUNT-1:0] cs;
    cs = '0;
    if (prog)
    begin
      cs[CS_MAIN] = pl.main_prog && ((a & MAIN_MASK) == MAIN_BASE);
      cs[CS_SEC]  = pl.sec_prog && ((a & SEC_MASK) == SEC_BASE);
    end
    else if ((a & CTRL_MASK) == CTRL_BASE)
      cs[CS_CTRL] = 1'b1;
    else if ((a & SRAM_MASK) == SRAM_BASE)
      cs[CS_SRAM] = 1'b1;
    else
    begin
      cs[CS_MAIN] = pl.main_data && ((a & MAIN_MASK) == MAIN_BASE);
      cs[CS_SEC]  = pl.sec_data && ((a & SEC_MASK) == SEC_BASE);
    end
    return cs;
  endfunction

  // direct, bit and register addressing share one byte path
  logic       accept;
  logic       is_bit;
  logic       dir_rd;
  logic       dir_wr;
  logic [7:0] dir_addr;
  logic [7:0] dir_val;
  logic [7:0] dir_wdata;
  logic [7:0] sreg_rdata;
  logic       sreg_we;
  logic [7:0] bit_mask;
  logic [7:0] reg_addr;
  logic [7:0] sp_inc;

  assign accept   = (state_q == ST_IDLE) && req.valid;
  assign is_bit   = (req.op == OP_BIT_SET) || (req.op == OP_BIT_CLR) ||
                    (req.op == OP_BIT_TST);
  assign bit_mask = 8'h01 << req.addr[2:0];
  assign reg_addr = INT_BASE + {3'b000, active_bank, req.addr[2:0]};
  assign sp_inc   = sp_q + 8'h01;

  always_comb
  begin
    dir_rd    = 1'b0;
    dir_wr    = 1'b0;
    dir_addr  = req.addr;
    dir_wdata = req.wdata;
    unique case (req.op)
      OP_DIR_RD:  dir_rd = 1'b1;
      OP_DIR_WR:  dir_wr = 1'b1;
      OP_REG_RD:
      begin
        dir_rd   = 1'b1;
        dir_addr = reg_addr;
      end
      OP_REG_WR:
      begin
        dir_wr   = 1'b1;
        dir_addr = reg_addr;
      end
      OP_BIT_SET, OP_BIT_CLR, OP_BIT_TST:
      begin
        dir_rd   = 1'b1;
        dir_wr   = (req.op != OP_BIT_TST);
        dir_addr = bit_byte(req.addr);
      end
      default:
      begin
        dir_rd = 1'b0;
      end
    endcase
    // high direct addresses go to the register space, never to upper RAM
    if (!dir_addr[7])
      dir_val = ram_q[dir_addr];
    else if (dir_addr == SP_ADDR)
      dir_val = sp_q;
    else if (dir_addr == PSW_ADDR)
      dir_val = psw_q;
    else
      dir_val = sreg_rdata;
    if (req.op == OP_BIT_SET)
      dir_wdata = dir_val | bit_mask;
    else if (req.op == OP_BIT_CLR)
      dir_wdata = dir_val & ~bit_mask;
  end

  assign sreg_we = accept && dir_wr && dir_addr[7] &&
                   (dir_addr != SP_ADDR) && (dir_addr != PSW_ADDR);

  special_register_store u_sreg (
    .clk   (clk),
    .wr_en (sreg_we),
    .waddr (dir_addr[6:0]),
    .wdata (dir_wdata),
    .raddr (dir_addr[6:0]),
    .rdata (sreg_rdata)
  );

  // internal RAM, lower and upper area
  always_ff @(posedge clk)
  begin
    if (accept && dir_wr && !dir_addr[7])
      ram_q[dir_addr] <= dir_wdata;
    else if (accept && (req.op == OP_IND_WR))
      ram_q[req.addr] <= req.wdata;
    else if (accept && (req.op == OP_PUSH))
      ram_q[sp_inc] <= req.wdata;
  end

  // stack pointer and status word
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sp_q  <= SP_RESET;
      psw_q <= PSW_RESET;
    end
    else if (accept)
    begin
      if (req.op == OP_PUSH)
        sp_q <= sp_inc;
      else if (req.op == OP_POP)
        sp_q <= sp_q - 8'h01;
      else if (dir_wr && (dir_addr == SP_ADDR))
        sp_q <= dir_wdata;
      if (dir_wr && (dir_addr == PSW_ADDR))
        psw_q <= dir_wdata;
    end
  end

  // program counter and interrupt vectors
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pc <= RESET_VECTOR;
    else if (accept)
    begin
      unique case (req.op)
        OP_FETCH: pc <= pc + 16'h0001;
        OP_JUMP:  pc <= req.wide;
        OP_IRQ:   pc <= VECTOR_BASE + 16'(VECTOR_STEP * req.addr[2:0]);
        default:  pc <= pc;
      endcase
    end
  end

  // two data pointers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      data_pointer_reg_q <= {DP_RESET, DP_RESET};
      dsel_q <= 1'b0;
    end
    else if (accept && (req.op == OP_DATA_POINTER_REG_LD))
      data_pointer_reg_q[req.addr[0]] <= req.wide;
    else if (accept && (req.op == OP_DATA_POINTER_REG_SEL))
      dsel_q <= req.addr[0];
  end

  // flash placement, loaded once after reset release
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      placement <= '0;
    else if (state_q == ST_LOAD)
      placement <= nv_placement;
    else if (accept && (req.op == OP_PLACE_WR))
      placement <= placement_s'(req.wdata[3:0]);
  end

  // sequencing of external accesses
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_LOAD;
      wait_q  <= '0;
      busy    <= 1'b1;
    end
    else
    begin
      unique case (state_q)
        ST_LOAD:
        begin
          state_q <= ST_IDLE;
          busy    <= 1'b0;
        end
        ST_IDLE:
        begin
          if (accept && ((req.op == OP_FETCH) || (req.op == OP_XRD) ||
                         (req.op == OP_XWR)))
          begin
            state_q <= ST_EXT;
            wait_q  <= CNT_W'(WAIT_CYCLES - 1);
            busy    <= 1'b1;
          end
        end
        ST_EXT:
        begin
          if (wait_q == '0)
          begin
            state_q <= ST_IDLE;
            busy    <= 1'b0;
          end
          else
            wait_q <= wait_q - 1'b1;
        end
      endcase
    end
  end

  // external strobes, address and segment selects
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ext_bus                        <= '0;
      ext_bus.program_fetch_strobe_n <= 1'b1;
      ext_bus.rd_n                   <= 1'b1;
      ext_bus.wr_n                   <= 1'b1;
      ext_read_q                     <= 1'b0;
    end
    else if (accept && (req.op == OP_FETCH))
    begin
      ext_bus.addr                   <= pc;
      ext_bus.page                   <= page;
      ext_bus.program_fetch_strobe_n <= 1'b0;
      ext_bus.cs                     <= seg_select(1'b1, pc, placement);
      ext_read_q                     <= 1'b1;
    end
    else if (accept && ((req.op == OP_XRD) || (req.op == OP_XWR)))
    begin
      ext_bus.addr  <= data_pointer_reg_q[dsel_q];
      ext_bus.page  <= page;
      ext_bus.wdata <= req.wdata;
      ext_bus.rd_n  <= (req.op != OP_XRD);
      ext_bus.wr_n  <= (req.op != OP_XWR);
      ext_bus.cs    <= seg_select(1'b0, data_pointer_reg_q[dsel_q], placement);
      ext_read_q    <= (req.op == OP_XRD);
    end
    else if ((state_q == ST_EXT) && (wait_q == '0))
    begin
      // end of the external strobe: all strobes return high and selects clear
      ext_bus.program_fetch_strobe_n <= 1'b1;
      ext_bus.rd_n                   <= 1'b1;
      ext_bus.wr_n                   <= 1'b1;
      ext_bus.cs                     <= '0;
      ext_read_q                     <= 1'b0;
    end
  end

  // answer to the core
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rsp <= '0;
    else if ((state_q == ST_EXT) && (wait_q == '0))
    begin
      rsp.valid   <= 1'b1;
      rsp.rdata   <= ext_read_q ? ext_rdata : 8'h00;
      rsp.bit_val <= 1'b0;
    end
    else if (accept && dir_rd)
    begin
      rsp.valid   <= 1'b1;
      rsp.rdata   <= dir_val;
      rsp.bit_val <= is_bit && |(dir_val & bit_mask);
    end
    else if (accept && (req.op == OP_IND_RD))
    begin
      rsp.valid   <= 1'b1;
      rsp.rdata   <= ram_q[req.addr];
      rsp.bit_val <= 1'b0;
    end
    else if (accept && (req.op == OP_POP))
    begin
      rsp.valid   <= 1'b1;
      rsp.rdata   <= ram_q[sp_q];
      rsp.bit_val <= 1'b0;
    end
    else
      rsp.valid <= 1'b0;
  end

  assign active_bank = psw_q[PSW_BANK_LSB +: 2];

endmodule
`default_nettype wire

// ### dv/memspace_properties.sv
/*
  Port checker for the memory space decoder.
  Assumes it is bound onto mcu_memory_space_decoder and sees its ports only.
*/
`timescale 1ns/10ps
`default_nettype none
module memspace_properties
  import memspace_pkg::*;
#(
  parameter int WAIT_CYCLES = EXT_WAIT_CYC
)
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // core side
  input wire core_req_s   req,
  input wire core_rsp_s   rsp,
  input wire logic        busy,
  input wire placement_s  nv_placement,
  // external side and state
  input wire ext_bus_s    ext_bus,
  input wire logic [15:0] pc,
  input wire placement_s  placement,
  input wire logic [1:0]  active_bank
);
  localparam int XLAT = WAIT_CYCLES + 1;
  logic       take;
  logic       strobe;
  logic [7:0] low_q;

  assign take = req.valid && !busy;
  assign strobe = !(ext_bus.program_fetch_strobe_n && ext_bus.rd_n && ext_bus.wr_n);

  // cycles with any strobe low
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      low_q <= 8'h00;
    else if (strobe)
      low_q <= low_q + 8'h01;
    else
      low_q <= 8'h00;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_take(op_e o);
    take && req.op == o;
  endsequence
  sequence s_int;
    take && req.op inside {OP_DIR_RD, OP_DIR_WR, OP_IND_RD, OP_IND_WR, OP_PUSH, OP_POP};
  endsequence
  sequence s_psw;
    take && req.op == OP_DIR_WR && req.addr == PSW_ADDR;
  endsequence

  a_fetch_strobe_only: assert property (!ext_bus.program_fetch_strobe_n
    |-> ext_bus.rd_n && ext_bus.wr_n)
    else $error("fetch strobe overlaps a data strobe");
  a_rd_wr_apart: assert property (!ext_bus.rd_n |-> ext_bus.wr_n)
    else $error("read and write strobes both low");
  a_strobe_width: assert property ($fell(strobe) |-> low_q == 8'(WAIT_CYCLES))
    else $error("strobe width wrong");
  a_internal_quiet: assert property (s_int |=> !strobe)
    else $error("internal access moved a strobe");
  a_int_answer: assert property (take
    && req.op inside {OP_DIR_RD, OP_IND_RD, OP_POP, OP_REG_RD} |=> rsp.valid && !strobe)
    else $error("internal read answer missing");
  a_reset_fetch: assert property ($rose(rstn) |-> pc == RESET_VECTOR)
    else $error("pc not at reset vector");
  a_place_load: assert property ($rose(rstn) |=> placement == nv_placement)
    else $error("placement not loaded");
  a_place_write: assert property (s_take(OP_PLACE_WR)
    |=> placement == $past(req.wdata[3:0]))
    else $error("placement write lost");
  a_irq_vector: assert property (s_take(OP_IRQ)
    |=> pc == VECTOR_BASE + VECTOR_STEP * {13'h0, $past(req.addr[2:0])})
    else $error("interrupt vector wrong");
  a_jump_target: assert property (s_take(OP_JUMP) |=> pc == $past(req.wide))
    else $error("jump target wrong");
  a_fetch_addr: assert property (s_take(OP_FETCH)
    |=> !ext_bus.program_fetch_strobe_n && ext_bus.addr == $past(pc)
    && pc == $past(pc) + 16'h0001)
    else $error("fetch address wrong");
  a_xrd_answer: assert property (s_take(OP_XRD) |-> ##XLAT rsp.valid)
    else $error("data read answer late");
  a_sram_data_only: assert property (!ext_bus.program_fetch_strobe_n
    |-> !ext_bus.cs[CS_SRAM] && !ext_bus.cs[CS_CTRL])
    else $error("sram selected in program space");
  a_prog_decode: assert property (!ext_bus.program_fetch_strobe_n
    |-> ext_bus.cs[CS_SEC] == (placement.sec_prog && ext_bus.addr[15]))
    else $error("program decode wrong");
  a_bank_psw: assert property (s_psw |=> active_bank == $past(req.wdata[4:3]))
    else $error("bank select wrong");
endmodule

bind mcu_memory_space_decoder memspace_properties #(.WAIT_CYCLES(WAIT_CYCLES)) u_props (
  .clk(clk), .rstn(rstn), .req(req), .rsp(rsp), .busy(busy), .nv_placement(nv_placement),
  .ext_bus(ext_bus), .pc(pc), .placement(placement), .active_bank(active_bank));
`default_nettype wire

// ### dv/mem_module_model.sv
/*
  Memory module model: answers fetch and data reads with an address pattern.
  Assumes the decoder samples read data only while a read strobe is low.
*/
`timescale 1ns/10ps
`default_nettype none
module mem_module_model
  import memspace_pkg::*;
(
  // clock
  input  wire logic     clk,
  // decoder bus
  input  wire ext_bus_s ext_bus,
  output logic [7:0]    ext_rdata
);
  logic       sel;
  logic [7:0] last_q;

  assign sel = !ext_bus.program_fetch_strobe_n || !ext_bus.rd_n;
  // page and selects are folded into the pattern; released bus shows the inverse of the last value
  assign ext_rdata = sel ? ext_bus.addr[7:0] ^ ext_bus.addr[15:8] ^ ext_bus.page
    ^ {4'h0, ext_bus.cs} : ~last_q;

  always_ff @(posedge clk)
    if (sel)
      last_q <= ext_rdata;
endmodule
`default_nettype wire

// ### dv/mcu_memory_space_decoder_bench.sv
/*
  Self-checking bench for the memory space decoder.
  Assumes the checker is bound and the memory module model is on the bus.
*/
`timescale 1ns/10ps
`default_nettype none
module mcu_memory_space_decoder_bench;
  import memspace_pkg::*;
  logic        clk;
  logic        rstn;
  core_req_s   req;
  core_rsp_s   rsp;
  logic        busy;
  placement_s  nv_placement;
  logic [7:0]  page;
  ext_bus_s    ext_bus;
  logic [7:0]  ext_rdata;
  logic [15:0] pc;
  placement_s  placement;
  logic [1:0]  active_bank;
  logic [7:0]  rd;
  int          bad_count;
  int          checked;

  mcu_memory_space_decoder #(.WAIT_CYCLES(4)) u_dut (.clk(clk), .rstn(rstn), .req(req),
    .rsp(rsp), .busy(busy), .nv_placement(nv_placement), .page(page), .ext_bus(ext_bus),
    .ext_rdata(ext_rdata), .pc(pc), .placement(placement), .active_bank(active_bank));
  mem_module_model u_mem (.clk(clk), .ext_bus(ext_bus), .ext_rdata(ext_rdata));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task finish_test;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function logic [15:0] xb(input logic [15:0] a, input logic [3:0] c);
    return {8'h00, a[7:0] ^ a[15:8] ^ page ^ {4'h0, c}};
  endfunction

  // one request; waits for the answer where one comes
  task op(input op_e o, input logic [7:0] a, input logic [7:0] d, input logic [15:0] w);
    int n;
    @(posedge clk);
    #1;
    req = '{1'b1, o, a, d, w};
    @(posedge clk);
    #1;
    req.valid = 1'b0;
    n = 0;
    if (o inside {OP_DIR_RD, OP_IND_RD, OP_POP, OP_REG_RD, OP_BIT_TST, OP_FETCH, OP_XRD, OP_XWR})
    begin
      while (rsp.valid !== 1'b1 && n < 20)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      // answer never came
      if (rsp.valid !== 1'b1)
        bad_count++;
    end
    rd = rsp.rdata;
  endtask

  task t_internal;
    op(OP_DIR_WR, 8'h30, 8'hA5, 16'h0);
    op(OP_IND_RD, 8'h30, 8'h00, 16'h0);
    check(16'(rd), 16'h00A5);
    op(OP_IND_WR, 8'h90, 8'h3C, 16'h0);
    op(OP_DIR_WR, 8'h90, 8'hC3, 16'h0);
    op(OP_IND_RD, 8'h90, 8'h00, 16'h0);
    check(16'(rd), 16'h003C);
    op(OP_DIR_RD, 8'h90, 8'h00, 16'h0);
    check(16'(rd), 16'h00C3);
    op(OP_DIR_WR, SP_ADDR, 8'h7F, 16'h0);
    op(OP_PUSH, 8'h00, 8'h66, 16'h0);
    op(OP_IND_RD, 8'h80, 8'h00, 16'h0);
    check(16'(rd), 16'h0066);
    op(OP_POP, 8'h00, 8'h00, 16'h0);
    check(16'(rd), 16'h0066);
    op(OP_DIR_RD, SP_ADDR, 8'h00, 16'h0);
    check(16'(rd), 16'h007F);
  endtask

  task t_banks;
    for (int n = 0; n < 4; n++)
    begin
      op(OP_DIR_WR, PSW_ADDR, {3'b000, 2'(n), 3'b000}, 16'h0);
      check(16'(active_bank), 16'(n));
      op(OP_REG_WR, 8'h05, 8'(8'h40 + n), 16'h0);
      op(OP_DIR_RD, 8'(8 * n + 5), 8'h00, 16'h0);
      check(16'(rd), 16'(8'h40 + n));
    end
    op(OP_DIR_WR, PSW_ADDR, 8'h00, 16'h0);
  endtask

  task t_bits;
    op(OP_DIR_WR, 8'h21, 8'h00, 16'h0);
    op(OP_BIT_SET, 8'h0A, 8'h00, 16'h0);
    op(OP_DIR_RD, 8'h21, 8'h00, 16'h0);
    check(16'(rd), 16'h0004);
    op(OP_BIT_TST, 8'h0A, 8'h00, 16'h0);
    check(16'(rsp.bit_val), 16'h0001);
    op(OP_BIT_CLR, 8'h0A, 8'h00, 16'h0);
    op(OP_BIT_TST, 8'h0A, 8'h00, 16'h0);
    check(16'(rsp.bit_val), 16'h0000);
    op(OP_BIT_SET, 8'hD3, 8'h00, 16'h0);
    check(16'(active_bank), 16'h0001);
    op(OP_BIT_CLR, 8'hD3, 8'h00, 16'h0);
  endtask

  task t_external;
    page = 8'h03;
    op(OP_JUMP, 8'h00, 8'h00, 16'h8010);
    op(OP_FETCH, 8'h00, 8'h00, 16'h0);
    check(16'(rd), xb(16'h8010, 4'b0010));
    check(pc, 16'h8011);
    op(OP_DATA_POINTER_REG_LD, 8'h00, 8'h00, 16'h2005);
    op(OP_DATA_POINTER_REG_LD, 8'h01, 8'h00, 16'h9000);
    op(OP_DATA_POINTER_REG_SEL, 8'h00, 8'h00, 16'h0);
    op(OP_XRD, 8'h00, 8'h00, 16'h0);
    check(16'(rd), xb(16'h2005, 4'b0100));
    op(OP_DATA_POINTER_REG_SEL, 8'h01, 8'h00, 16'h0);
    op(OP_XRD, 8'h00, 8'h00, 16'h0);
    check(16'(rd), xb(16'h9000, 4'b0010));
    op(OP_XWR, 8'h00, 8'h5A, 16'h0);
    check(16'(rd), 16'h0000);
    check(16'(ext_bus.wdata), 16'h005A);
    op(OP_DATA_POINTER_REG_LD, 8'h00, 8'h00, 16'h0210);
    op(OP_DATA_POINTER_REG_SEL, 8'h00, 8'h00, 16'h0);
    op(OP_XRD, 8'h00, 8'h00, 16'h0);
    check(16'(rd), xb(16'h0210, 4'b1000));
    op(OP_PLACE_WR, 8'h00, 8'h04, 16'h0);
    op(OP_DATA_POINTER_REG_LD, 8'h00, 8'h00, 16'h1234);
    op(OP_XRD, 8'h00, 8'h00, 16'h0);
    check(16'(rd), xb(16'h1234, 4'b0001));
    op(OP_FETCH, 8'h00, 8'h00, 16'h0);
    check(16'(rd), xb(16'h8011, 4'b0000));
    op(OP_PLACE_WR, 8'h00, 8'h0B, 16'h0);
    op(OP_FETCH, 8'h00, 8'h00, 16'h0);
    check(16'(rd), xb(16'h8012, 4'b0010));
    for (int n = 0; n < 3; n++)
    begin
      op(OP_IRQ, 8'(n), 8'h00, 16'h0);
      check(pc, 16'(16'h0003 + 8 * n));
    end
  endtask

  // reset in mid-run, then reload of placement
  task t_reset;
    nv_placement = 4'b0110;
    @(posedge clk);
    #1;
    rstn = 1'b0;
    #1;
    check(pc, RESET_VECTOR);
    check(16'(busy), 16'h0001);
    @(posedge clk);
    #1;
    rstn = 1'b1;
    @(posedge clk);
    #1;
    check(16'(placement), 16'h0006);
    op(OP_DIR_RD, SP_ADDR, 8'h00, 16'h0);
    check(16'(rd), 16'(SP_RESET));
  endtask

  initial
  begin
    rstn = 1'b0;
    req = '0;
    nv_placement = 4'b1011;
    page = 8'h00;
    bad_count = 0;
    checked = 0;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    @(posedge clk);
    #1;
    check(pc, RESET_VECTOR);
    check(16'(placement), 16'h000B);
    t_internal;
    t_banks;
    t_bits;
    t_external;
    t_reset;
    finish_test;
  end

  initial
  begin
    #(25 * 4000);
    bad_count++;
    finish_test;
  end
endmodule
`default_nettype wire
